// >>> test/mri_mem_model.sv
// Registered program and data memory answering the interpreter's word requests.
`timescale 1ns/1ps
module mri_mem_model (
    input wire logic i_clk,
    input wire mri_pkg::mri_mem_req_t i_mem,
    output logic [15:0] o_rdata
);
    logic [15:0] pmem [0:256-1];
    logic [15:0] dmem [0:256-1];

    // Both spaces start with a pattern that tells them apart.
    initial begin
        for (int i = 0; i < 256; i++) begin
            pmem[i] = {8'ha5, 8'(i)};
            dmem[i] = {8'h5a, 8'(i)};
        end
        o_rdata = 16'h0000;
    end

    // Writes land in the chosen space; read data stands one cycle, otherwise the bus toggles.
    always @(posedge i_clk) begin
        if (i_mem.req && i_mem.we && i_mem.data_space) begin
            dmem[i_mem.addr[7:0]] <= i_mem.wdata;
        end
        if (i_mem.req && i_mem.we && !i_mem.data_space) begin
            pmem[i_mem.addr[7:0]] <= i_mem.wdata;
        end
        if (i_mem.req && !i_mem.we) begin
            o_rdata <= i_mem.data_space ? dmem[i_mem.addr[7:0]] : pmem[i_mem.addr[7:0]];
        end else begin
            o_rdata <= ~o_rdata;
        end
    end
endmodule // mri_mem_model

// >>> test/mri_top_bench.sv
// Self-checking bench for the mailbox request interpreter.
`timescale 1ns/1ps
module mri_top_bench;
    localparam int TICK = 4;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic mb_wr = 1'b0;
    logic mb_rd = 1'b0;
    logic [5:0] mb_addr = 6'h00;
    logic [15:0] mb_wdata = 16'h0000;
    logic sem_wr = 1'b0;
    logic [1:0] sem_idx = 2'h0;
    logic sem_wdata = 1'b0;
    logic [15:0] mb_rdata;
    logic [15:0] mem_rdata;
    logic [2:0] sem_o;
    mri_pkg::mri_mem_req_t mem;
    mri_pkg::mri_tone_cfg_t tone_cfg;
    mri_pkg::mri_dial_cfg_t dial_cfg;
    logic tone_on;
    logic mute;
    logic drop;
    logic dropped;
    int miscompares = 0;
    int n_checks = 0;
    int cycles = 0;

    mri_top #(.TICK_CYCLES(TICK)) uut (.I_SYS_CLK(clk), .I_RST(rst), .I_MB_WR(mb_wr), .I_MB_RD(mb_rd),
        .I_MB_ADDR(mb_addr), .I_MB_WDATA(mb_wdata), .O_MB_RDATA(mb_rdata), .I_SEM_WR(sem_wr),
        .I_SEM_IDX(sem_idx), .I_SEM_WDATA(sem_wdata), .O_SEM(sem_o), .O_MEM(mem), .I_MEM_RDATA(mem_rdata),
        .O_TONE_CFG(tone_cfg), .O_TONE_ON(tone_on), .O_MUTE_OTHERS(mute), .O_DIAL_CFG(dial_cfg),
        .O_REQ_DROP(drop));
    mri_mem_model mdl (.i_clk(clk), .i_mem(mem), .o_rdata(mem_rdata));

    // Free-running clock and a cycle ceiling that cuts a hang short.
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            miscompares++;
            end_of_test();
        end
    end

    task automatic check(input string name, input logic [95:0] seen, input logic [95:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        mb_wr = 1'b1;
        mb_addr = a;
        mb_wdata = d;
        @(negedge clk);
        mb_wr = 1'b0;
        @(negedge clk);
    endtask

    task automatic rd(input logic [5:0] a, output logic [15:0] d);
        mb_rd = 1'b1;
        mb_addr = a;
        @(negedge clk);
        mb_rd = 1'b0;
        d = mb_rdata;
        @(negedge clk);
    endtask

    task automatic sem(input logic [1:0] idx, input logic v);
        sem_wr = 1'b1;
        sem_idx = idx;
        sem_wdata = v;
        @(negedge clk);
        sem_wr = 1'b0;
    endtask

    // Waits a bounded time for the device to release a semaphore, noting any discard pulse.
    task automatic wait_clear(input int idx);
        int n;
        n = 0;
        dropped = 1'b0;
        do begin
            @(negedge clk);
            dropped |= drop;
            n++;
        end while (sem_o[idx] !== 1'b0 && n < 100);
        @(negedge clk);
        dropped |= drop;
        check("semaphore", 96'(sem_o[idx]), 96'h0);
    endtask

    task automatic mem_op(input logic [15:0] cmd, input logic [15:0] adr, input logic [15:0] cnt,
                          input logic [15:0] a, input logic [15:0] b);
        wr(6'h00, cmd);
        wr(6'h01, adr);
        wr(6'h02, cnt);
        wr(6'h03, a);
        wr(6'h04, b);
        sem(2'h0, 1'b1);
        wait_clear(0);
    endtask

    task automatic req(input logic [15:0] len, input logic [15:0] code, input logic [95:0] p);
        wr(6'h20, len);
        wr(6'h21, code);
        for (int i = 0; i < 6; i++) begin
            wr(6'h22 + 6'(i), p[95 - 16 * i -: 16]);
        end
        sem(2'h1, 1'b1);
        wait_clear(1);
    endtask

    // All four memory commands, with the address stepping and the two spaces kept apart.
    task automatic t_mem_access();
        logic [15:0] d;
        mem_op(mri_pkg::CMD_DATA_WR, 16'habcd, 16'h0002, 16'h1234, 16'h5678);
        check("data words", {mdl.dmem[8'hcd], mdl.dmem[8'hce]}, 96'h12345678);
        mem_op(mri_pkg::CMD_PROG_WR, 16'habcd, 16'h0001, 16'h1111, 16'h2222);
        check("prog words", {mdl.pmem[8'hcd], mdl.pmem[8'hce]}, 96'h1111a5ce);
        mem_op(mri_pkg::CMD_DATA_RD, 16'habcd, 16'h0003, 16'h0bad, 16'h0bad);
        for (int i = 0; i < 3; i++) begin
            rd(6'h03 + 6'(i), d);
            check("data read", 96'(d), 96'(i == 2 ? 16'h5acf : (i == 1 ? 16'h5678 : 16'h1234)));
        end
        mem_op(mri_pkg::CMD_PROG_RD, 16'habcd, 16'h0002, 16'h0bad, 16'h0bad);
        rd(6'h04, d);
        check("prog read", 96'(d), 96'ha5ce);
    endtask

    // Bad command, zero count and oversize count touch no memory and still release.
    task automatic t_mem_refuse();
        logic [15:0] d;
        mem_op(16'h0005, 16'h0000, 16'h0001, 16'h0bad, 16'h0bad);
        mem_op(mri_pkg::CMD_DATA_WR, 16'h0000, 16'h0000, 16'h0bad, 16'h0bad);
        mem_op(mri_pkg::CMD_DATA_WR, 16'h0000, 16'h001e, 16'h0bad, 16'h0bad);
        check("untouched", 96'(mdl.dmem[8'h00]), 96'h5a00);
        rd(6'h03, d);
        check("payload kept", 96'(d), 96'h0bad);
    endtask

    // Immediate timed tone with muting, then the completion status.
    task automatic t_tone_auto();
        logic [15:0] d;
        logic [95:0] p;
        int n;
        p = {16'h5a82, 16'h5a83, 16'h4000, 16'h0002, 16'h0002, 16'h0003};
        req(mri_pkg::LEN_TONE_CFG, mri_pkg::REQ_TONE_CFG, p);
        check("tone cfg", 96'(tone_cfg), p);
        check("tone on", 96'({tone_on, mute}), 96'h3);
        n = 0;
        while (sem_o[2] !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        check("done", 96'({sem_o[2], tone_on, mute, n >= 3 * TICK}), 96'h9);
        rd(mri_pkg::MB_STAT_CODE[5:0], d);
        check("status", 96'(d), 96'(mri_pkg::STAT_TONE_DONE));
        sem(2'h2, 1'b0);
    endtask

    // Deferred unlimited tone, start, stop, then discarded requests leave it alone.
    task automatic t_tone_manual();
        logic [95:0] p;
        p = {16'h1000, 16'h2000, 16'h3000, 16'h0000, 16'h0000, 16'h0000};
        req(mri_pkg::LEN_TONE_CFG, mri_pkg::REQ_TONE_CFG, p);
        check("waits", 96'({tone_on, mute}), 96'h0);
        req(mri_pkg::LEN_SHORT, mri_pkg::REQ_TONE_START, 96'h0);
        repeat (10 * TICK) @(negedge clk);
        check("started", 96'({tone_on, mute}), 96'h2);
        req(mri_pkg::LEN_SHORT, mri_pkg::REQ_TONE_STOP, 96'h0);
        check("stopped", 96'({sem_o[2], tone_on}), 96'h0);
        req(16'h0002, mri_pkg::REQ_TONE_CFG, {96{1'b1}});
        check("bad length", 96'({dropped, tone_on}), 96'h2);
        req(mri_pkg::LEN_SHORT, 16'h0803, 96'h0);
        check("bad code", 96'(dropped), 96'h1);
        check("cfg kept", 96'(tone_cfg), p);
    endtask

    task automatic t_dial();
        logic [95:0] p;
        p = {16'h2414, 16'h2d6b, 16'h0064, 16'h0000, 32'h0};
        req(mri_pkg::LEN_DIAL_CFG, mri_pkg::REQ_DIAL_CFG, p);
        check("dial cfg", 96'(dial_cfg), 96'(p[95:32]));
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        repeat (6) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        t_mem_access();
        t_mem_refuse();
        t_tone_auto();
        t_tone_manual();
        t_dial();
        end_of_test();
    end
endmodule // mri_top_bench

// >>> verilog/mri_pkg.sv
// Shared constants and carrier types for the mailbox request interpreter.
package mri_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MEM_WORDS = 32;
    localparam int REQ_WORDS = 16;
    localparam logic [4:0] OFS_CMD = 5'h00;
    localparam logic [4:0] OFS_ADDR = 5'h01;
    localparam logic [4:0] OFS_COUNT = 5'h02;
    localparam logic [4:0] OFS_PAYLOAD = 5'h03;
    localparam logic [15:0] MAX_COUNT = 16'h001d;
    localparam logic [15:0] CMD_PROG_RD = 16'h0001;
    localparam logic [15:0] CMD_PROG_WR = 16'h0002;
    localparam logic [15:0] CMD_DATA_RD = 16'h0003;
    localparam logic [15:0] CMD_DATA_WR = 16'h0004;
    localparam logic [3:0] W_LEN = 4'h0;
    localparam logic [3:0] W_CODE = 4'h1;
    localparam logic [3:0] W_COS = 4'h2;
    localparam logic [3:0] W_SIN = 4'h3;
    localparam logic [3:0] W_LVL = 4'h4;
    localparam logic [3:0] W_ON = 4'h5;
    localparam logic [3:0] W_GAP = 4'h6;
    localparam logic [3:0] W_CTRL = 4'h7;
    localparam logic [3:0] W_DLOW = 4'h2;
    localparam logic [3:0] W_DHIGH = 4'h3;
    localparam logic [3:0] W_DON = 4'h4;
    localparam logic [3:0] W_DGAP = 4'h5;
    localparam logic [15:0] REQ_TONE_CFG = 16'h0800;
    localparam logic [15:0] LEN_TONE_CFG = 16'h0007;
    localparam logic [15:0] REQ_TONE_START = 16'h0801;
    localparam logic [15:0] REQ_TONE_STOP = 16'h0802;
    localparam logic [15:0] LEN_SHORT = 16'h0001;
    localparam logic [15:0] REQ_DIAL_CFG = 16'h0820;
    localparam logic [15:0] LEN_DIAL_CFG = 16'h0005;
    localparam logic [15:0] STAT_LEN = 16'h0001;
    localparam logic [15:0] STAT_TONE_DONE = 16'h8801;
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_MUTE_BIT = 1;
    localparam int SEM_MEM = 0;
    localparam int SEM_REQ = 1;
    localparam int SEM_STAT = 2;
    localparam int SEM_NUM = 3;
    localparam logic [5:0] MB_STAT_BASE = 6'h30;
    localparam logic [5:0] MB_STAT_CODE = 6'h31;
    localparam logic [1:0] MB_REQ_SPACE = 2'h2;
    localparam logic [15:0] RST_WORD = 16'h0000;

    typedef struct packed {
        logic [15:0] cos_coef;
        logic [15:0] sin_coef;
        logic [15:0] level;
        logic [15:0] on_ms;
        logic [15:0] gap_ms;
        logic [15:0] ctrl;
    } mri_tone_cfg_t;

    typedef struct packed {
        logic [15:0] dial_low_group_amp;
        logic [15:0] dial_high_group_amp;
        logic [15:0] dial_on_time_ms;
        logic [15:0] dial_gap_ms;
    } mri_dial_cfg_t;

    typedef struct packed {
        logic req;
        logic we;
        logic data_space;
        logic [15:0] addr;
        logic [15:0] wdata;
    } mri_mem_req_t;
endpackage

// >>> verilog/mri_tone_timer.sv
// Tone-on and silence sequencer with a millisecond prescaler.
`timescale 1ns/1ps
module mri_tone_timer #(
    parameter int MS_CYCLES = mri_pkg::MS_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_start,
    input wire logic i_stop,
    input wire logic i_mute_en,
    input wire logic [15:0] i_on_ms,
    input wire logic [15:0] i_gap_ms,
    output logic o_sounding,
    output logic o_mute,
    output logic o_done
);
    localparam int PW = $clog2(MS_CYCLES + 1);
    typedef enum logic [1:0] {T_IDLE, T_ON, T_GAP} mri_tstate_t;
    mri_tstate_t state;
    mri_tstate_t next_state;
    logic [PW-1:0] pre;
    logic [15:0] ms;
    logic tick;
    logic ms_end;
    logic next_done;

    assign tick = pre == PW'(MS_CYCLES - 1);

    // A zero length never ends its phase, so only a stop or a restart leaves it.
    always_comb begin
        next_state = state;
        next_done = 1'b0;
        if (state == T_ON) begin
            ms_end = i_on_ms != 16'h0000 && ms + 16'h0001 == i_on_ms;
        end else begin
            ms_end = i_gap_ms != 16'h0000 && ms + 16'h0001 == i_gap_ms;
        end
        if (i_stop) begin
            next_state = T_IDLE;
        end else if (i_start) begin
            next_state = T_ON;
        end else begin
            unique case (state)
                T_IDLE: next_state = T_IDLE;
                T_ON: if (tick && ms_end) next_state = T_GAP;
                T_GAP: if (tick && ms_end) begin
                    next_state = T_IDLE;
                    next_done = 1'b1;
                end
            endcase
        end
    end

    // State and registered outputs.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state <= T_IDLE;
            o_sounding <= 1'b0;
            o_mute <= 1'b0;
            o_done <= 1'b0;
        end else begin
            state <= next_state;
            o_sounding <= next_state == T_ON;
            o_mute <= next_state == T_ON && i_mute_en;
            o_done <= next_done;
        end
    end

    // Millisecond prescaler and phase counter restart with every phase.
    always_ff @(posedge i_clk) begin
        if (i_rst || i_start || i_stop || state == T_IDLE) begin
            pre <= '0;
            ms <= 16'h0000;
        end else if (tick) begin
            pre <= '0;
            ms <= ms_end ? 16'h0000 : ms + 16'h0001;
        end else begin
            pre <= pre + PW'(1);
        end
    end

    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);

    chk_unlimited_tone: assert property (
        state == T_ON && i_on_ms == 16'h0000 && !i_stop && !i_start |=> state == T_ON)
        else $error("Unlimited tone ended by itself.");
endmodule // mri_tone_timer

// >>> verilog/mri_top.sv
// Mailbox request interpreter: memory access, request dispatch, tone control.
`timescale 1ns/1ps
module mri_top #(
    parameter int TICK_CYCLES = mri_pkg::MS_CYCLES
) (
    input wire logic I_SYS_CLK,
    input wire logic I_RST,
    input wire logic I_MB_WR,
    input wire logic I_MB_RD,
    input wire logic [5:0] I_MB_ADDR,
    input wire logic [15:0] I_MB_WDATA,
    output logic [15:0] O_MB_RDATA,
    input wire logic I_SEM_WR,
    input wire logic [1:0] I_SEM_IDX,
    input wire logic I_SEM_WDATA,
    output logic [2:0] O_SEM,
    output mri_pkg::mri_mem_req_t O_MEM,
    input wire logic [15:0] I_MEM_RDATA,
    output mri_pkg::mri_tone_cfg_t O_TONE_CFG,
    output logic O_TONE_ON,
    output logic O_MUTE_OTHERS,
    output mri_pkg::mri_dial_cfg_t O_DIAL_CFG,
    output logic O_REQ_DROP
);
    typedef enum logic [1:0] {M_IDLE, M_RUN, M_DRAIN} mri_mstate_t;

    logic [15:0] mb_mem [mri_pkg::MEM_WORDS];
    logic [15:0] mb_req [mri_pkg::REQ_WORDS];
    mri_mstate_t mstate;
    logic [15:0] cur_addr;
    logic [15:0] remain;
    logic [15:0] count_q;
    logic [15:0] acc_cnt;
    logic [4:0] idx;
    logic [4:0] cidx1;
    logic [4:0] cidx2;
    logic op_we;
    logic op_data;
    logic op_valid;
    logic pend1;
    logic pend2;
    logic mem_clr;
    logic [15:0] cmd;
    logic [15:0] cnt;
    logic cmd_rd;
    logic cmd_wr;
    logic cnt_ok;
    logic [15:0] req_len;
    logic [15:0] req_code;
    logic req_go;
    logic is_cfg;
    logic is_start;
    logic is_stop;
    logic is_dial;
    logic req_known;
    logic tone_start;
    logic tone_stop;
    logic tone_done;
    logic [15:0] rd_mux;
    mri_pkg::mri_tone_cfg_t next_tone_cfg;
    logic [2:0] host_set;
    logic [2:0] host_clr;
    logic [2:0] dev_set;
    logic [2:0] dev_clr;
    logic [2:0] next_sem;

    // Memory-access command decode from the mailbox words.
    assign cmd = mb_mem[mri_pkg::OFS_CMD];
    assign cnt = mb_mem[mri_pkg::OFS_COUNT];
    assign cmd_rd = cmd == mri_pkg::CMD_PROG_RD || cmd == mri_pkg::CMD_DATA_RD;
    assign cmd_wr = cmd == mri_pkg::CMD_PROG_WR || cmd == mri_pkg::CMD_DATA_WR;
    assign cnt_ok = cnt <= mri_pkg::MAX_COUNT;
    assign mem_clr = mstate == M_DRAIN && !pend1 && !pend2;

    // Transfer sequencer; a bad command or an oversize count is released untouched.
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            mstate <= M_IDLE;
            cur_addr <= mri_pkg::RST_WORD;
            remain <= mri_pkg::RST_WORD;
            count_q <= mri_pkg::RST_WORD;
            idx <= mri_pkg::OFS_PAYLOAD;
            op_we <= 1'b0;
            op_data <= 1'b0;
            op_valid <= 1'b0;
        end else begin
            unique case (mstate)
                M_IDLE: if (O_SEM[mri_pkg::SEM_MEM]) begin
                    cur_addr <= mb_mem[mri_pkg::OFS_ADDR];
                    remain <= cnt;
                    count_q <= cnt;
                    idx <= mri_pkg::OFS_PAYLOAD;
                    op_we <= cmd_wr;
                    op_data <= cmd == mri_pkg::CMD_DATA_RD || cmd == mri_pkg::CMD_DATA_WR;
                    op_valid <= (cmd_rd || cmd_wr) && cnt_ok;
                    if ((cmd_rd || cmd_wr) && cnt_ok && cnt != mri_pkg::RST_WORD) begin
                        mstate <= M_RUN;
                    end else begin
                        mstate <= M_DRAIN;
                    end
                end
                M_RUN: begin
                    cur_addr <= cur_addr + 16'h0001;
                    idx <= idx + 5'h01;
                    remain <= remain - 16'h0001;
                    if (remain == 16'h0001) begin
                        mstate <= M_DRAIN;
                    end
                end
                M_DRAIN: if (mem_clr) mstate <= M_IDLE;
            endcase
        end
    end

    // Memory port: one word per cycle, read data returns two edges after issue.
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            O_MEM <= '0;
            pend1 <= 1'b0;
            pend2 <= 1'b0;
            cidx1 <= mri_pkg::OFS_PAYLOAD;
            cidx2 <= mri_pkg::OFS_PAYLOAD;
        end else begin
            O_MEM.req <= mstate == M_RUN;
            O_MEM.we <= op_we;
            O_MEM.data_space <= op_data;
            O_MEM.addr <= cur_addr;
            O_MEM.wdata <= mb_mem[idx];
            pend1 <= mstate == M_RUN && !op_we;
            pend2 <= pend1;
            cidx1 <= idx;
            cidx2 <= cidx1;
        end
    end

    // Access counter used to check the transfer length.
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST || mstate == M_IDLE) begin
            acc_cnt <= mri_pkg::RST_WORD;
        end else if (O_MEM.req) begin
            acc_cnt <= acc_cnt + 16'h0001;
        end
    end

    // Mailbox storage; a returning read word overrides a host write to the same word.
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            for (int k = 0; k < mri_pkg::MEM_WORDS; k++) begin
                mb_mem[k] <= mri_pkg::RST_WORD;
            end
            for (int k = 0; k < mri_pkg::REQ_WORDS; k++) begin
                mb_req[k] <= mri_pkg::RST_WORD;
            end
        end else begin
            if (I_MB_WR && !I_MB_ADDR[5]) begin
                mb_mem[I_MB_ADDR[4:0]] <= I_MB_WDATA;
            end
            if (I_MB_WR && I_MB_ADDR[5:4] == mri_pkg::MB_REQ_SPACE) begin
                mb_req[I_MB_ADDR[3:0]] <= I_MB_WDATA;
            end
            if (pend2) begin
                mb_mem[cidx2] <= I_MEM_RDATA;
            end
        end
    end

    // Request framing: the length must match what the code defines.
    assign req_len = mb_req[mri_pkg::W_LEN];
    assign req_code = mb_req[mri_pkg::W_CODE];
    assign req_go = O_SEM[mri_pkg::SEM_REQ];
    assign is_cfg = req_len == mri_pkg::LEN_TONE_CFG && req_code == mri_pkg::REQ_TONE_CFG;
    assign is_start = req_len == mri_pkg::LEN_SHORT && req_code == mri_pkg::REQ_TONE_START;
    assign is_stop = req_len == mri_pkg::LEN_SHORT && req_code == mri_pkg::REQ_TONE_STOP;
    assign is_dial = req_len == mri_pkg::LEN_DIAL_CFG && req_code == mri_pkg::REQ_DIAL_CFG;
    assign req_known = is_cfg || is_start || is_stop || is_dial;

    // A start without prior setup plays whatever settings are held.
    assign tone_start = req_go && (is_start || (is_cfg && mb_req[mri_pkg::W_CTRL][mri_pkg::CTRL_START_BIT]));
    assign tone_stop = req_go && is_stop;

    // Tone settings as they stand after this cycle's request.
    always_comb begin
        next_tone_cfg = O_TONE_CFG;
        if (req_go && is_cfg) begin
            next_tone_cfg.cos_coef = mb_req[mri_pkg::W_COS];
            next_tone_cfg.sin_coef = mb_req[mri_pkg::W_SIN];
            next_tone_cfg.level = mb_req[mri_pkg::W_LVL];
            next_tone_cfg.on_ms = mb_req[mri_pkg::W_ON];
            next_tone_cfg.gap_ms = mb_req[mri_pkg::W_GAP];
            next_tone_cfg.ctrl = mb_req[mri_pkg::W_CTRL];
        end
    end

    // Configuration registers and the drop pulse.
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            O_TONE_CFG <= '0;
            O_DIAL_CFG <= '0;
            O_REQ_DROP <= 1'b0;
        end else begin
            O_TONE_CFG <= next_tone_cfg;
            if (req_go && is_dial) begin
                O_DIAL_CFG.dial_low_group_amp <= mb_req[mri_pkg::W_DLOW];
                O_DIAL_CFG.dial_high_group_amp <= mb_req[mri_pkg::W_DHIGH];
                O_DIAL_CFG.dial_on_time_ms <= mb_req[mri_pkg::W_DON];
                O_DIAL_CFG.dial_gap_ms <= mb_req[mri_pkg::W_DGAP];
            end
            O_REQ_DROP <= req_go && !req_known;
        end
    end

    // Tone sequencer.
    mri_tone_timer #(
        .MS_CYCLES(TICK_CYCLES)
    ) u_timer (
        .i_clk(I_SYS_CLK),
        .i_rst(I_RST),
        .i_start(tone_start),
        .i_stop(tone_stop),
        .i_mute_en(next_tone_cfg.ctrl[mri_pkg::CTRL_MUTE_BIT]),
        .i_on_ms(next_tone_cfg.on_ms),
        .i_gap_ms(next_tone_cfg.gap_ms),
        .o_sounding(O_TONE_ON),
        .o_mute(O_MUTE_OTHERS),
        .o_done(tone_done)
    );

    // Semaphores: a set from either side wins over a clear in the same cycle.
    assign dev_set = {tone_done, 1'b0, 1'b0};
    assign dev_clr = {1'b0, req_go, mem_clr};
    generate
        for (genvar g = 0; g < mri_pkg::SEM_NUM; g++) begin : g_sem
            assign host_set[g] = I_SEM_WR && I_SEM_IDX == 2'(g) && I_SEM_WDATA;
            assign host_clr[g] = I_SEM_WR && I_SEM_IDX == 2'(g) && !I_SEM_WDATA;
            assign next_sem[g] = host_set[g] || dev_set[g] || (O_SEM[g] && !host_clr[g] && !dev_clr[g]);
        end
    endgenerate

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            O_SEM <= 3'h0;
        end else begin
            O_SEM <= next_sem;
        end
    end

    // Host read mux; unmapped words read as zero.
    always_comb begin
        if (!I_MB_ADDR[5]) begin
            rd_mux = mb_mem[I_MB_ADDR[4:0]];
        end else if (I_MB_ADDR[5:4] == mri_pkg::MB_REQ_SPACE) begin
            rd_mux = mb_req[I_MB_ADDR[3:0]];
        end else if (I_MB_ADDR == mri_pkg::MB_STAT_BASE) begin
            rd_mux = mri_pkg::STAT_LEN;
        end else if (I_MB_ADDR == mri_pkg::MB_STAT_CODE) begin
            rd_mux = mri_pkg::STAT_TONE_DONE;
        end else begin
            rd_mux = mri_pkg::RST_WORD;
        end
    end

    // Read data is registered and holds until the next read.
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            O_MB_RDATA <= mri_pkg::RST_WORD;
        end else if (I_MB_RD) begin
            O_MB_RDATA <= rd_mux;
        end
    end

    default clocking @(posedge I_SYS_CLK); endclocking
    default disable iff (I_RST);

    chk_cmd_kind: assert property (
        O_MEM.req |-> O_MEM.we == (cmd == mri_pkg::CMD_PROG_WR || cmd == mri_pkg::CMD_DATA_WR))
        else $error("Access kind does not follow the command.");

    chk_first_addr: assert property (
        O_MEM.req && !$past(O_MEM.req) |-> O_MEM.addr == mb_mem[mri_pkg::OFS_ADDR])
        else $error("First access is not at the given address.");

    // A write releases while its last word is still on the bus, so that word is counted here.
    chk_count_exact: assert property (
        mem_clr && op_valid |-> acc_cnt + (O_MEM.req ? 16'h0001 : 16'h0000) == count_q)
        else $error("Access count differs from the requested count.");

    chk_read_store: assert property (
        pend2 |=> mb_mem[$past(cidx2)] == $past(I_MEM_RDATA))
        else $error("Read word not placed in the mailbox.");

    chk_mem_release: assert property (
        mem_clr && !host_set[mri_pkg::SEM_MEM] |=> !O_SEM[mri_pkg::SEM_MEM] && mstate == M_IDLE)
        else $error("Memory semaphore not cleared on completion.");

    chk_addr_step: assert property (
        O_MEM.req && $past(O_MEM.req) |-> O_MEM.addr == $past(O_MEM.addr) + 16'h0001)
        else $error("Address did not step by one.");

    chk_drop_bad: assert property (
        req_go && !req_known && !host_set[mri_pkg::SEM_REQ] |=> O_REQ_DROP && !O_SEM[mri_pkg::SEM_REQ])
        else $error("Unknown request not dropped and released.");

    chk_cfg_load: assert property (
        req_go && is_cfg |=> O_TONE_CFG.cos_coef == $past(mb_req[mri_pkg::W_COS])
            && O_TONE_CFG.on_ms == $past(mb_req[mri_pkg::W_ON]))
        else $error("Tone setup words not loaded.");

    chk_start_sounds: assert property (
        tone_start |=> O_TONE_ON)
        else $error("Tone did not start on request.");

    chk_stop_halts: assert property (
        tone_stop |=> !O_TONE_ON ##1 !O_TONE_ON)
        else $error("Tone still sounding after stop.");

    chk_mute_scope: assert property (
        O_MUTE_OTHERS |-> O_TONE_ON && O_TONE_CFG.ctrl[mri_pkg::CTRL_MUTE_BIT])
        else $error("Mute outside a muting tone.");

    chk_done_post: assert property (
        tone_done |=> O_SEM[mri_pkg::SEM_STAT])
        else $error("Completion status not posted.");
endmodule // mri_top
